// ===== inc/oua_pkg.sv
// Purpose: Shared constants and state types of the octal serial ancillary block
// Assumes: Single 200 MHz clock, synchronous active-low reset
// Notes: Register map of the ancillary block and field positions
// ==========================================================================
// Package
package oua_pkg;
	localparam int NUM_CH = 8;
	localparam int QUEUE_DEPTH = 16;
	localparam int CLK_PERIOD_NS = 5;
	// Address decode
	localparam logic [7:0] GLOBAL_BIT = 8'h80;
	localparam logic [3:0] MCR_OFS = 4'h4;
	localparam logic [3:0] MSR_OFS = 4'h6;
	localparam logic [7:0] ISR0_ADR = 8'h80;
	localparam logic [7:0] ISR1_ADR = 8'h81;
	localparam logic [7:0] ISR2_ADR = 8'h82;
	localparam logic [7:0] ISR3_ADR = 8'h83;
	localparam logic [7:0] TMR_LO_ADR = 8'h84;
	localparam logic [7:0] TMR_HI_ADR = 8'h85;
	localparam logic [7:0] TMR_CTL_ADR = 8'h86;
	// Modem control field positions
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_IR_BIT = 6;
	localparam int MCR_PRESC_BIT = 7;
	// Modem status field positions
	localparam int MSR_CTS_BIT = 4;
	localparam int MSR_DSR_BIT = 5;
	localparam int MSR_RI_BIT = 6;
	localparam int MSR_CD_BIT = 7;
	// Interrupt source 1 field positions
	localparam int ISR1_TMR_BIT = 0;
	localparam int ISR1_WAKE_BIT = 1;
	// Reset values and limits
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [15:0] TMR_RST = 16'h0000;
	localparam logic [15:0] TMR_MAX = 16'hFFFF;
	localparam logic [1:0] PRESC_LAST = 2'h3;
	localparam logic [1:0] PRESC_RST = 2'h0;

	typedef struct packed {
		logic [NUM_CH-1:0][7:0] modem_control_reg;
		logic strap_pend;
		logic rd_lvl;
		logic wr_lvl;
		logic [7:0] rd_data;
		logic tmr_clk;
		logic tmr_en;
		logic [15:0] tmr_cnt;
		logic tmr_int;
	} oua_state_t;

	typedef struct packed {
		logic [NUM_CH-1:0][1:0] cnt;
	} oua_presc_state_t;
endpackage : oua_pkg

// ===== inc/oua_presc_if.sv
// Purpose: Carrier between control logic and the per-channel prescaler
// Assumes: Both ends on sys_clk_i
// Notes: One select bit and one tick per channel
`timescale 1ns/1ps
// ==========================================================================
// Interface
interface oua_presc_if;
	logic [7:0] div4_sel;
	logic [7:0] tick;
	modport ctl (output div4_sel, input tick);
	modport gen (input div4_sel, output tick);
endinterface : oua_presc_if

// ===== rtl/oua_prescale.sv
// Purpose: Per-channel prescaler feeding each baud rate generator
// Assumes: Select bit may change at any time; counter restarts cleanly
// Notes: Tick is a one-cycle enable, every cycle or every fourth
`timescale 1ns/1ps
module oua_prescale import oua_pkg::*; (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Control side
	oua_presc_if.gen presc
);
	oua_presc_state_t st_q;
	oua_presc_state_t st_d;

	// ==================================================================
	// Divider
	always_comb begin
		st_d = st_q;
		for (int c = 0; c < NUM_CH; c++) begin
			if (!presc.div4_sel[c] || st_q.cnt[c] == PRESC_LAST) begin
				st_d.cnt[c] = PRESC_RST;
			end else begin
				st_d.cnt[c] = st_q.cnt[c] + 2'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Divide by one passes every clock; divide by four every fourth
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			presc.tick[c] = !presc.div4_sel[c] || (st_q.cnt[c] == PRESC_LAST);
		end
	end

	// ==================================================================
	// Checks
	property p_div4_gap;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(presc.div4_sel[0] && presc.tick[0]) ##1 presc.div4_sel[0][*3]
			|-> !presc.tick[0] && !$past(presc.tick[0]) && !$past(presc.tick[0], 2)
			##1 presc.tick[0];
	endproperty
	a_div4_gap: assert property (p_div4_gap) else $error("Prescale by four gap wrong");
endmodule : oua_prescale

// ===== rtl/oua_ancillary.sv
// Purpose: Ancillary control of an eight-channel serial device
// Assumes: All pins synchronous to sys_clk_i; queues and line logic live elsewhere
// Notes: Host access taken on the leading edge of the decoded strobe
// ==========================================================================
// Summary of operation
// - Eight serial channels, one general timer/counter, sys_clk_i clocks the logic.
// - Each channel has its own 16-byte transmit and receive queues.
// - Each channel prescaler divides the input clock by one or four.
// - Four consecutive interrupt source registers cover channels, timer and wake-up.
// - Channel 7 request-to-send output active low, or general output.
// - Channel 7 terminal-ready output active low, or general output.
// - Channel 7 clear-to-send input active low, or general input.
// - Channel 7 set-ready, carrier and ring inputs active low, or general inputs.
// - The 16-bit timer counts rising edges of the external timer clock pin.
// - Infrared strap sampled after hardware reset and after software reset.
// - Sampled strap level lands in bit 6 of every modem control register.
// - Hardware reset returns configuration and channel registers to defaults.
// - Bus select high picks separate strobes; low picks the alternative style.
// - Bus select changes meaning of read strobe, write strobe and chip select.
// - Oscillator input takes crystal or clock; output gives buffered clock. Here a plain buffer, so a clock only.
// - Chip select low, address bit 7 zero: bits 6 to 4 pick channel.
`timescale 1ns/1ps
module oua_ancillary import oua_pkg::*; (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic sw_reset_i,
	// Host bus
	input wire logic bus_sel_i,
	input wire logic chip_sel_n_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	output logic [7:0] rd_data_o,
	// Event sources
	input wire logic [7:0] chan_int_i,
	input wire logic wake_i,
	// Channel 7 modem pins
	output logic ch7_request_to_send_n_o,
	output logic ch7_terminal_ready_n_o,
	input wire logic ch7_clear_to_send_n_i,
	input wire logic ch7_set_ready_n_i,
	input wire logic ch7_carrier_detect_n_i,
	input wire logic ch7_ring_indicator_n_i,
	// Clocks and strap
	input wire logic osc_input_i,
	output logic osc_output_o,
	input wire logic timer_ext_clock_i,
	input wire logic infrared_startup_strap_i,
	// Status
	output logic [7:0] ir_mode_o,
	output logic [7:0] baud_tick_o,
	output logic [15:0] timer_count_o,
	output logic timer_int_o
);
	oua_state_t st_q;
	oua_state_t st_d;
	logic rd_lvl;
	logic wr_lvl;
	logic rd_pulse;
	logic wr_pulse;
	logic tmr_rise;

	oua_presc_if presc ();

	// ==================================================================
	// Helpers
	function automatic logic is_chan_reg(input logic [7:0] adr, input logic [3:0] ofs);
		is_chan_reg = ((adr & GLOBAL_BIT) == 8'h00) && (adr[3:0] == ofs);
	endfunction : is_chan_reg

	// ==================================================================
	// Bus style decode
	always_comb begin
		if (bus_sel_i) begin
			rd_lvl = !chip_sel_n_i && !read_strobe_n_i;
			wr_lvl = !chip_sel_n_i && !write_strobe_n_i;
		end else begin
			// Chip select is the strobe, write strobe pin is the direction
			rd_lvl = !chip_sel_n_i && write_strobe_n_i;
			wr_lvl = !chip_sel_n_i && !write_strobe_n_i;
		end
	end

	// Leading edge only, so a long strobe is one access
	assign rd_pulse = rd_lvl && !st_q.rd_lvl;
	assign wr_pulse = wr_lvl && !st_q.wr_lvl;
	// Pin is taken as synchronous; one stage gives the previous level
	assign tmr_rise = timer_ext_clock_i && !st_q.tmr_clk;

	// ==================================================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.rd_lvl = rd_lvl;
		st_d.wr_lvl = wr_lvl;
		st_d.tmr_clk = timer_ext_clock_i;
		st_d.strap_pend = 1'b0;
		if (st_q.strap_pend) begin
			for (int c = 0; c < NUM_CH; c++) begin
				st_d.modem_control_reg[c][MCR_IR_BIT] = infrared_startup_strap_i;
			end
		end
		if (wr_pulse) begin
			if (is_chan_reg(addr_i, MCR_OFS)) begin
				st_d.modem_control_reg[addr_i[6:4]] = wr_data_i;
			end else if (addr_i == TMR_CTL_ADR) begin
				st_d.tmr_en = wr_data_i[0];
			end
		end
		if (st_q.tmr_en && tmr_rise) begin
			st_d.tmr_cnt = st_q.tmr_cnt + 16'h0001;
		end
		if (rd_pulse) begin
			st_d.rd_data = 8'h00;
			if (is_chan_reg(addr_i, MCR_OFS)) begin
				st_d.rd_data = st_q.modem_control_reg[addr_i[6:4]];
			end else if (is_chan_reg(addr_i, MSR_OFS) && addr_i[6:4] == 3'h7) begin
				st_d.rd_data[MSR_CTS_BIT] = !ch7_clear_to_send_n_i;
				st_d.rd_data[MSR_DSR_BIT] = !ch7_set_ready_n_i;
				st_d.rd_data[MSR_RI_BIT] = !ch7_ring_indicator_n_i;
				st_d.rd_data[MSR_CD_BIT] = !ch7_carrier_detect_n_i;
			end else begin
				unique case (addr_i)
					ISR0_ADR: st_d.rd_data = chan_int_i;
					ISR1_ADR: begin
						st_d.rd_data[ISR1_TMR_BIT] = st_q.tmr_int;
						st_d.rd_data[ISR1_WAKE_BIT] = wake_i;
						st_d.tmr_int = 1'b0;
					end
					ISR2_ADR: st_d.rd_data = 8'h00;
					ISR3_ADR: st_d.rd_data = 8'h00;
					TMR_LO_ADR: st_d.rd_data = st_q.tmr_cnt[7:0];
					TMR_HI_ADR: st_d.rd_data = st_q.tmr_cnt[15:8];
					TMR_CTL_ADR: st_d.rd_data = {7'h00, st_q.tmr_en};
					default: st_d.rd_data = 8'h00;
				endcase
			end
		end
		// Set wins over the clear by read
		if (st_q.tmr_en && tmr_rise && st_q.tmr_cnt == TMR_MAX) begin
			st_d.tmr_int = 1'b1;
		end
		// Soft reset clears channel registers and resamples the strap
		if (sw_reset_i) begin
			for (int c = 0; c < NUM_CH; c++) begin
				st_d.modem_control_reg[c] = MCR_RST;
			end
			st_d.strap_pend = 1'b1;
		end
	end

	// ==================================================================
	// State register
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
			st_q.tmr_cnt <= TMR_RST;
			st_q.strap_pend <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ==================================================================
	// Prescalers
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			presc.div4_sel[c] = st_q.modem_control_reg[c][MCR_PRESC_BIT];
		end
	end

	// Queues of QUEUE_DEPTH bytes per channel sit past the tick, outside this logic
	oua_prescale u_presc (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.presc(presc.gen)
	);

	// ==================================================================
	// Outputs
	assign ch7_request_to_send_n_o = !st_q.modem_control_reg[7][MCR_RTS_BIT];
	assign ch7_terminal_ready_n_o = !st_q.modem_control_reg[7][MCR_DTR_BIT];
	// Plain buffer; no crystal amplifier in this logic
	assign osc_output_o = osc_input_i;
	assign rd_data_o = st_q.rd_data;
	assign baud_tick_o = presc.tick;
	assign timer_count_o = st_q.tmr_cnt;
	assign timer_int_o = st_q.tmr_int;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			ir_mode_o[c] = st_q.modem_control_reg[c][MCR_IR_BIT];
		end
	end

	// ==================================================================
	// Checks
	property p_rts_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr_pulse && is_chan_reg(addr_i, MCR_OFS) && addr_i[6:4] == 3'h7 && !sw_reset_i)
			|=> ch7_request_to_send_n_o == !$past(wr_data_i[1]);
	endproperty
	a_rts_write: assert property (p_rts_write) else $error("RTS pin not inverse of bit");

	property p_dtr_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr_pulse && is_chan_reg(addr_i, MCR_OFS) && addr_i[6:4] == 3'h7 && !sw_reset_i)
			|=> ch7_terminal_ready_n_o == !$past(wr_data_i[0]);
	endproperty
	a_dtr_write: assert property (p_dtr_write) else $error("DTR pin not inverse of bit");

	property p_cts_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(rd_pulse && addr_i == 8'h76) |=> rd_data_o[4] == !$past(ch7_clear_to_send_n_i);
	endproperty
	a_cts_read: assert property (p_cts_read) else $error("CTS status wrong");

	property p_msr_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(rd_pulse && addr_i == 8'h76) |=> rd_data_o[7:5] == ~$past({ch7_carrier_detect_n_i,
			ch7_ring_indicator_n_i, ch7_set_ready_n_i});
	endproperty
	a_msr_read: assert property (p_msr_read) else $error("Modem status wrong");

	property p_strap;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_q.strap_pend && !sw_reset_i) |=> ir_mode_o == {8{$past(infrared_startup_strap_i)}};
	endproperty
	a_strap: assert property (p_strap) else $error("Strap not copied to all channels");

	property p_soft_reset;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		sw_reset_i |=> ch7_request_to_send_n_o && ch7_terminal_ready_n_o && st_q.strap_pend;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("Soft reset incomplete");

	property p_timer_step;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_q.tmr_en && tmr_rise) |=> timer_count_o == $past(timer_count_o) + 16'h0001;
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("Timer did not step");

	property p_timer_wrap;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_q.tmr_en && tmr_rise && timer_count_o == TMR_MAX) |=> timer_int_o ##0
			timer_count_o == TMR_RST;
	endproperty
	a_timer_wrap: assert property (p_timer_wrap) else $error("Timer wrap not flagged");

	property p_cs_gate;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(chip_sel_n_i && !sw_reset_i && !st_q.strap_pend) |=> $stable(st_q.modem_control_reg);
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("Write without chip select");
endmodule : oua_ancillary

// ===== testbench/oua_host_model.sv
// Purpose: Host processor model on the parallel bus
// Assumes: Outputs change just after a rising edge
// Notes: Strobe held two edges, so each access is taken once
`timescale 1ns/1ps
module oua_host_model import oua_pkg::*; (
	// Clock
	input wire logic sys_clk_i,
	// Bus
	output logic bus_sel_o,
	output logic chip_sel_n_o,
	output logic read_strobe_n_o,
	output logic write_strobe_n_o,
	output logic [7:0] addr_o,
	output logic [7:0] wr_data_o,
	input wire logic [7:0] rd_data_i
);
	// ======
	// Bus cycles
	initial begin
		bus_sel_o = 1'b1;
		chip_sel_n_o = 1'b1;
		read_strobe_n_o = 1'b1;
		write_strobe_n_o = 1'b1;
		addr_o = 8'h00;
		wr_data_o = 8'h00;
	end
	task automatic set_style(input logic s);
		@(posedge sys_clk_i);
		bus_sel_o <= s;
	endtask : set_style
	// Cs_on low leaves chip select off, for refusal cases
	task automatic access(input logic wr, input logic cs_on, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk_i);
		addr_o <= a;
		wr_data_o <= d;
		chip_sel_n_o <= ~cs_on;
		read_strobe_n_o <= bus_sel_o ? wr : 1'b1;
		write_strobe_n_o <= ~wr;
		repeat (2) @(posedge sys_clk_i);
		chip_sel_n_o <= 1'b1;
		read_strobe_n_o <= 1'b1;
		write_strobe_n_o <= 1'b1;
		// Released lines must not keep the last value
		addr_o <= ~a;
		wr_data_o <= ~d;
		repeat (2) @(posedge sys_clk_i);
		q = rd_data_i;
	endtask : access
endmodule : oua_host_model

// ===== testbench/octal_uart_ancillary_control_bench.sv
// Purpose: Self-checking bench of the ancillary control block
// Assumes: Host model drives the bus; pins are driven here
// Notes: Timer overflow needs 65536 edges, too long for this run
`timescale 1ns/1ps
module octal_uart_ancillary_control_bench import oua_pkg::*;;
	logic clk, rst_n, sw_rst, osc_in, osc_out, tmr_ck, strap, wake, rts_n, dtr_n, tint;
	logic bsel, cs_n, rd_n, wr_n;
	logic [7:0] adr, wdat, rdat, cint, irm, tick;
	logic [3:0] pins;
	logic [15:0] tcnt;
	int err_count = 0;
	int check_count = 0;
	oua_host_model oua_host_model_inst (.sys_clk_i(clk), .bus_sel_o(bsel),
		.chip_sel_n_o(cs_n), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
		.addr_o(adr), .wr_data_o(wdat), .rd_data_i(rdat));
	oua_ancillary oua_ancillary_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .sw_reset_i(sw_rst),
		.bus_sel_i(bsel), .chip_sel_n_i(cs_n), .read_strobe_n_i(rd_n),
		.write_strobe_n_i(wr_n), .addr_i(adr), .wr_data_i(wdat), .rd_data_o(rdat),
		.chan_int_i(cint), .wake_i(wake), .ch7_request_to_send_n_o(rts_n),
		.ch7_terminal_ready_n_o(dtr_n), .ch7_clear_to_send_n_i(pins[0]),
		.ch7_set_ready_n_i(pins[1]), .ch7_ring_indicator_n_i(pins[2]),
		.ch7_carrier_detect_n_i(pins[3]), .osc_input_i(osc_in), .osc_output_o(osc_out),
		.timer_ext_clock_i(tmr_ck), .infrared_startup_strap_i(strap), .ir_mode_o(irm),
		.baud_tick_o(tick), .timer_count_o(tcnt), .timer_int_o(tint));
	// ======
	// Helpers
	task automatic end_of_test;
		$display("Checks %0d, errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		oua_host_model_inst.access(1'b0, 1'b1, a, 8'h00, q);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		oua_host_model_inst.access(1'b1, 1'b1, a, d, q);
		#1;
	endtask : wr
	task automatic tpulse(input int n);
		repeat (n) begin
			@(posedge clk) tmr_ck <= 1'b1;
			@(posedge clk) tmr_ck <= 1'b0;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask : tpulse
	// ======
	// Scenarios
	task automatic hw_reset(input logic s);
		logic [7:0] q;
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("rts", rts_n, 1'b1);
		check("dtr", dtr_n, 1'b1);
		check("tcnt", tcnt, 16'h0000);
		check("tint", tint, 1'b0);
		check("tick", tick, 8'hFF);
		check("rdat", rdat, 8'h00);
		check("irm", irm, {8{s}});
		rd(8'h04, q);
		check("mcr0", q, {1'b0, s, 6'h00});
	endtask : hw_reset
	task automatic t_mout;
		logic [7:0] q;
		wr(8'h74, 8'h02);
		check("rts", rts_n, 1'b0);
		check("dtr", dtr_n, 1'b1);
		wr(8'h74, 8'h01);
		check("rts", rts_n, 1'b1);
		check("dtr", dtr_n, 1'b0);
		rd(8'h74, q);
		check("mcr7", q, 8'h01);
		check("irm", irm, 8'h7F);
	endtask : t_mout
	task automatic t_min;
		logic [7:0] q;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) pins <= 4'hF ^ (4'h1 << i);
			rd(8'h76, q);
			check("msr7", q & 8'hF0, 8'h10 << i);
		end
		rd(8'h36, q);
		check("msr3", q, 8'h00);
		@(posedge clk) pins <= 4'hF;
	endtask : t_min
	task automatic t_presc;
		logic [15:0] n1 = 16'h0000;
		logic [15:0] n2 = 16'h0000;
		wr(8'h04, 8'h80);
		repeat (16) begin
			@(posedge clk);
			#1;
			n1 += tick[1];
			n2 += tick[0];
		end
		check("tick1", n1, 16'h0010);
		check("tick0", n2, 16'h0004);
		wr(8'h04, 8'h00);
		check("tick", tick, 8'hFF);
	endtask : t_presc
	task automatic t_timer;
		logic [7:0] q;
		wr(TMR_CTL_ADR, 8'h01);
		tpulse(3);
		check("tcnt", tcnt, 16'h0003);
		rd(TMR_LO_ADR, q);
		check("tlo", q, 8'h03);
		rd(TMR_HI_ADR, q);
		check("thi", q, 8'h00);
		rd(TMR_CTL_ADR, q);
		check("tctl", q, 8'h01);
		wr(TMR_CTL_ADR, 8'h00);
		tpulse(2);
		check("tcnt", tcnt, 16'h0003);
	endtask : t_timer
	task automatic t_isr;
		logic [7:0] q;
		@(posedge clk);
		cint <= 8'hA5;
		wake <= 1'b1;
		rd(ISR0_ADR, q);
		check("isr0", q, 8'hA5);
		rd(ISR1_ADR, q);
		check("isr1", q & 8'h03, 8'h02);
		rd(ISR2_ADR, q);
		check("isr2", q, 8'h00);
		rd(ISR3_ADR, q);
		check("isr3", q, 8'h00);
		rd(8'h8F, q);
		check("unmapped", q, 8'h00);
	endtask : t_isr
	task automatic t_style;
		logic [7:0] q;
		oua_host_model_inst.set_style(1'b0);
		wr(8'h74, 8'h03);
		check("rts", rts_n, 1'b0);
		rd(8'h74, q);
		check("mcr7", q, 8'h03);
		oua_host_model_inst.access(1'b1, 1'b0, 8'h74, 8'h00, q);
		#1 check("rts", rts_n, 1'b0);
		oua_host_model_inst.set_style(1'b1);
		@(posedge clk) osc_in <= 1'b1;
		#1 check("osc", osc_out, 1'b1);
		@(posedge clk) osc_in <= 1'b0;
		#1 check("osc", osc_out, 1'b0);
	endtask : t_style
	task automatic t_swrst;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			strap <= i[0];
			sw_rst <= 1'b1;
			@(posedge clk) sw_rst <= 1'b0;
			repeat (2) @(posedge clk);
			#1;
			check("irm", irm, {8{i[0]}});
			check("rts", rts_n, 1'b1);
		end
	endtask : t_swrst
	// ======
	// Main sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{rst_n, sw_rst, osc_in, tmr_ck, strap, wake} = 6'h00;
		cint = 8'h00;
		pins = 4'hF;
		hw_reset(1'b1);
		t_mout();
		t_min();
		t_presc();
		t_timer();
		t_isr();
		t_style();
		t_swrst();
		wr(8'h74, 8'h03);
		hw_reset(1'b0);
		end_of_test();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("ERROR watchdog expected end seen hang");
		end_of_test();
	end
endmodule : octal_uart_ancillary_control_bench
